// ### hw/msmr_top.sv
/*
 msmr_top: third-input warning flags, conversion update flags, password
 entry, table select, first-table user memory and first alarm mask byte,
 with the maskable interrupt bit. Assumes a byte access port behind the
 two-wire interface and a conversion engine and configuration bytes that
 run on the same clock.
*/
`timescale 1ns/100ps
`include "msmr_regs.svh"
module msmr_top #(
	parameter logic [31:0] LOWER_PASSWORD = 32'h1111_1111, // arbitrary value
	parameter logic [31:0] UPPER_PASSWORD = 32'h2222_2222  // arbitrary value
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [7:0]  acc_addr,
	input  wire logic        acc_wr,
	input  wire logic        acc_rd,
	input  wire logic [7:0]  acc_wdata,
	input  wire logic [4:0]  conv_done,
	input  wire logic        third_above_warn,
	input  wire logic        third_below_warn,
	input  wire logic        power_range_indicator,
	input  wire logic [9:0]  alarm_flags,
	input  wire logic [7:0]  other_warn_flags,
	input  wire logic [23:0] other_first_masks,
	input  wire logic [19:0] second_set_masks,
	input  wire logic        mask_set_select,
	input  wire logic        shadow_volatile,
	input  wire logic [2:0]  table_select_default,
	output logic      [7:0]  rd_data_q,
	output logic             rd_valid_q,
	output logic      [2:0]  table_select_q,
	output logic      [1:0]  third_warn_flags_q,
	output logic             lower_password_level_q,
	output logic             upper_password_level_q,
	output logic             maskable_interrupt_bit
);
	// nonvolatile stores start at the factory default
	logic [7:0]            user_mem [0:`MSMR_USER_DEPTH-1] = '{default: `MSMR_NV_DEFAULT};
	logic [7:0]            mask_nv = `MSMR_NV_DEFAULT;
	logic [7:0]            mask_live_q;
	logic [4:0]            upd_q;
	logic [31:0]           pw_q;
	logic                  range_q;
	logic [7:0]            rd_addr_q;
	logic [7:0]            rd_d;
	msmr_pkg::msmr_state_e state_q;
	logic                  run;
	logic                  wr_ok;
	logic                  rd_ok;
	logic                  upd_wr;

	msmr_irq_if irq_bus();

	function automatic logic in_user(input logic [7:0] a, input logic [2:0] t);
		in_user = (t == `MSMR_TBL_USER) && (a >= `MSMR_OFS_USER_FIRST) && (a <= `MSMR_OFS_USER_LAST);
	endfunction

	function automatic logic is_mask(input logic [7:0] a, input logic [2:0] t);
		is_mask = (t == `MSMR_TBL_USER) && (a == `MSMR_OFS_MASK1);
	endfunction

	function automatic logic is_pw(input logic [7:0] a);
		is_pw = (a >= `MSMR_OFS_PW_FIRST) && (a <= `MSMR_OFS_PW_LAST);
	endfunction

	// byte lane of the password word, lowest address is the top byte
	function automatic logic [1:0] pw_lane(input logic [7:0] a);
		logic [7:0] d;
		d = `MSMR_OFS_PW_LAST - a;
		pw_lane = d[1:0];
	endfunction

	// one cycle of startup load before accesses are taken
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= msmr_pkg::MSMR_ST_LOAD;
		end else begin
			case (state_q)
				msmr_pkg::MSMR_ST_LOAD: state_q <= msmr_pkg::MSMR_ST_RUN;
				msmr_pkg::MSMR_ST_RUN:  state_q <= msmr_pkg::MSMR_ST_RUN;
				default:                state_q <= msmr_pkg::MSMR_ST_LOAD;
			endcase
		end
	end

	assign run    = (state_q == msmr_pkg::MSMR_ST_RUN);
	assign wr_ok  = run && acc_wr;
	assign rd_ok  = run && acc_rd;
	assign upd_wr = wr_ok && (acc_addr == `MSMR_OFS_UPD);

	always_ff @(posedge clock) begin
		if (rst)
			table_select_q <= `MSMR_RST_TBL;
		else if (!run)
			table_select_q <= table_select_default;
		else if (wr_ok && acc_addr == `MSMR_OFS_TBL)
			table_select_q <= acc_wdata[2:0];
	end

	always_ff @(posedge clock) begin
		if (rst)
			third_warn_flags_q <= 2'h0;
		else if (conv_done[`MSMR_CH_THIRD])
			third_warn_flags_q <= {third_above_warn, third_below_warn};
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			upd_q <= `MSMR_RST_UPD;
		end else begin
			for (int i = 0; i < `MSMR_NUM_CH; i++) begin
				if (conv_done[i])
					upd_q[i] <= 1'b1;
				else if (upd_wr && !acc_wdata[i + `MSMR_UPD_LSB])
					upd_q[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			range_q <= 1'b0;
		else
			range_q <= power_range_indicator;
	end

	always_ff @(posedge clock) begin
		if (rst)
			pw_q <= `MSMR_RST_PW;
		else if (wr_ok && is_pw(acc_addr))
			pw_q[8*pw_lane(acc_addr) +: 8] <= acc_wdata;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			lower_password_level_q <= 1'b0;
			upper_password_level_q <= 1'b0;
		end else begin
			upper_password_level_q <= (pw_q == UPPER_PASSWORD);
			lower_password_level_q <= (pw_q == LOWER_PASSWORD) || (pw_q == UPPER_PASSWORD);
		end
	end

	always_ff @(posedge clock) begin
		if (wr_ok && in_user(acc_addr, table_select_q))
			user_mem[acc_addr[6:0]] <= acc_wdata;
	end

	// nonvolatile copy only when not volatile
	always_ff @(posedge clock) begin
		if (wr_ok && is_mask(acc_addr, table_select_q) && !shadow_volatile)
			mask_nv <= acc_wdata;
	end

	always_ff @(posedge clock) begin
		if (rst)
			mask_live_q <= `MSMR_NV_DEFAULT;
		else if (!run)
			mask_live_q <= mask_nv;
		else if (wr_ok && is_mask(acc_addr, table_select_q))
			mask_live_q <= acc_wdata;
	end

	// read decode
	always_comb begin
		rd_d = 8'h00;
		case (acc_addr)
			`MSMR_OFS_WARN3: rd_d = {third_warn_flags_q, 6'h00};
			`MSMR_OFS_UPD:   rd_d = {upd_q, 2'h0, range_q};
			`MSMR_OFS_TBL:   rd_d = {5'h00, table_select_q};
			default: begin
				if (in_user(acc_addr, table_select_q))
					rd_d = user_mem[acc_addr[6:0]];
				else if (is_mask(acc_addr, table_select_q))
					rd_d = mask_live_q;
				else if (is_pw(acc_addr))
					rd_d = pw_q[8*pw_lane(acc_addr) +: 8];
				else
					rd_d = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rd_data_q  <= 8'h00;
			rd_valid_q <= 1'b0;
			rd_addr_q  <= 8'h00;
		end else begin
			rd_valid_q <= rd_ok;
			if (rd_ok) begin
				rd_data_q <= rd_d;
				rd_addr_q <= acc_addr;
			end
		end
	end

	// first mask byte in flag order
	assign irq_bus.flags  = {alarm_flags, other_warn_flags, third_warn_flags_q};
	assign irq_bus.mask_a = {mask_live_q, other_first_masks[23:22], other_first_masks[15:8],
		other_first_masks[7:6]};
	assign irq_bus.mask_b = second_set_masks;
	assign irq_bus.sel    = mask_set_select;
	assign maskable_interrupt_bit = irq_bus.irq;

	msmr_irq_gen u_irq (
		.clock (clock),
		.rst   (rst),
		.bus   (irq_bus.gen)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_hi_warn;
		conv_done[`MSMR_CH_THIRD] |=> third_warn_flags_q[`MSMR_WARN_HI_BIT] == $past(third_above_warn);
	endproperty
	a_hi_warn: assert property (p_hi_warn) else $error("high warning not captured");

	property p_lo_warn;
		conv_done[`MSMR_CH_THIRD] |=> third_warn_flags_q[`MSMR_WARN_LO_BIT] == $past(third_below_warn);
	endproperty
	a_lo_warn: assert property (p_lo_warn) else $error("low warning not captured");

	property p_warn_hold;
		!conv_done[`MSMR_CH_THIRD] |=> $stable(third_warn_flags_q);
	endproperty
	a_warn_hold: assert property (p_warn_hold) else $error("warning changed without conversion");

	property p_upd_set;
		conv_done[`MSMR_CH_TEMP] |=> upd_q[`MSMR_CH_TEMP];
	endproperty
	a_upd_set: assert property (p_upd_set) else $error("temperature update flag not set");

	property p_upd_clr;
		(upd_wr && !acc_wdata[7] && !conv_done[`MSMR_CH_TEMP]) |=> !upd_q[`MSMR_CH_TEMP];
	endproperty
	a_upd_clr: assert property (p_upd_clr) else $error("zero write did not clear update flag");

	property p_upd_read;
		(rd_ok && acc_addr == `MSMR_OFS_UPD) |=> rd_data_q == {$past(upd_q), 2'h0, $past(range_q)} && rd_valid_q;
	endproperty
	a_upd_read: assert property (p_upd_read) else $error("update byte read wrong");

	property p_upd_zero;
		(rd_valid_q && rd_addr_q == `MSMR_OFS_UPD) |-> rd_data_q[2:1] == 2'h0;
	endproperty
	a_upd_zero: assert property (p_upd_zero) else $error("update bits two and one not zero");

	property p_pw_top;
		(wr_ok && acc_addr == `MSMR_OFS_PW_FIRST) |=> pw_q[31:24] == $past(acc_wdata);
	endproperty
	a_pw_top: assert property (p_pw_top) else $error("password top byte not stored");

	property p_levels;
		(pw_q == UPPER_PASSWORD) |=> upper_password_level_q && lower_password_level_q;
	endproperty
	a_levels: assert property (p_levels) else $error("upper level missing lower access");

	property p_tbl_read;
		(rd_valid_q && rd_addr_q == `MSMR_OFS_TBL) |-> rd_data_q[7:3] == 5'h00;
	endproperty
	a_tbl_read: assert property (p_tbl_read) else $error("table select high bits not zero");

	property p_tbl_load;
		(state_q == msmr_pkg::MSMR_ST_LOAD) |=> table_select_q == $past(table_select_default);
	endproperty
	a_tbl_load: assert property (p_tbl_load) else $error("table select not loaded at startup");

	property p_shadow_volatile;
		(wr_ok && shadow_volatile) |=> $stable(mask_nv);
	endproperty
	a_shadow_volatile: assert property (p_shadow_volatile) else $error("volatile write reached store");

	property p_rsv_read;
		(rd_ok && acc_addr == `MSMR_OFS_RSV_A) |=> rd_data_q == 8'h00;
	endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("reserved byte not zero");

	property p_range;
		1'b1 |=> range_q == $past(power_range_indicator);
	endproperty
	a_range: assert property (p_range) else $error("range indicator not registered");

	property p_tbl_write;
		(wr_ok && acc_addr == `MSMR_OFS_TBL) |=> table_select_q == $past(acc_wdata[2:0]);
	endproperty
	a_tbl_write: assert property (p_tbl_write) else $error("table select write lost");

	property p_user_write;
		(wr_ok && in_user(acc_addr, table_select_q)) |=> user_mem[$past(acc_addr[6:0])] == $past(acc_wdata);
	endproperty
	a_user_write: assert property (p_user_write) else $error("user memory write lost");

	property p_temp_hi_irq;
		(alarm_flags[9] && mask_live_q[7] && !mask_set_select) |=> maskable_interrupt_bit;
	endproperty
	a_temp_hi_irq: assert property (p_temp_hi_irq) else $error("temperature high alarm not routed");

	property p_mask_live;
		(wr_ok && is_mask(acc_addr, table_select_q)) |=> mask_live_q == $past(acc_wdata);
	endproperty
	a_mask_live: assert property (p_mask_live) else $error("mask byte write lost");

	c_upd_cycle: cover property (upd_wr && !acc_wdata[7] ##[1:20] upd_q[`MSMR_CH_TEMP]);
	c_upper: cover property ($rose(upper_password_level_q));
	c_mask_write: cover property (wr_ok && is_mask(acc_addr, table_select_q) && !shadow_volatile);
endmodule // msmr_top

// ### hw/msmr_regs.svh
/*
 msmr_regs.svh: offsets, field positions and reset values of the monitor
 status and mask register bank. Assumes byte-wide addresses 00h to FFh.
*/
`ifndef MSMR_REGS_SVH
`define MSMR_REGS_SVH

`define MSMR_OFS_WARN3       8'h75
`define MSMR_OFS_RSV_A       8'h76
`define MSMR_OFS_UPD         8'h77
`define MSMR_OFS_PW_FIRST    8'h7B
`define MSMR_OFS_PW_LAST     8'h7E
`define MSMR_OFS_TBL         8'h7F
`define MSMR_OFS_USER_FIRST  8'h80
`define MSMR_OFS_USER_LAST   8'hF7
`define MSMR_OFS_MASK1       8'hF8

`define MSMR_TBL_USER        3'h1
`define MSMR_USER_DEPTH      120
`define MSMR_NUM_CH          5
`define MSMR_CH_TEMP         4
`define MSMR_CH_THIRD        0
`define MSMR_UPD_LSB         3
`define MSMR_WARN_HI_BIT     1
`define MSMR_WARN_LO_BIT     0

`define MSMR_RST_UPD         5'h00
`define MSMR_RST_PW          32'h0000_0000
`define MSMR_RST_TBL         3'h0
`define MSMR_NV_DEFAULT      8'h00

`endif

// ### hw/msmr_pkg.sv
/*
 msmr_pkg: types shared by the monitor status and mask register bank.
 Assumes nothing of its surroundings.
*/
package msmr_pkg;

	typedef enum logic [1:0] {
		MSMR_ST_LOAD = 2'b01,
		MSMR_ST_RUN  = 2'b10
	} msmr_state_e;

	// alarms [19:10], warnings [9:0]; within each: temp hi/lo, supply hi/lo, inputs 1..3 hi/lo
	typedef logic [19:0] msmr_flags_t;

endpackage

// ### hw/msmr_irq_if.sv
/*
 msmr_irq_if: flags, both mask sets and the set select carried from the
 register bank to the interrupt generator, and the interrupt back.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface msmr_irq_if;
	msmr_pkg::msmr_flags_t flags;
	msmr_pkg::msmr_flags_t mask_a;
	msmr_pkg::msmr_flags_t mask_b;
	logic                  sel;
	logic                  irq;

	modport src (output flags, output mask_a, output mask_b, output sel, input irq);
	modport gen (input flags, input mask_a, input mask_b, input sel, output irq);
endinterface

// ### hw/msmr_irq_gen.sv
/*
 msmr_irq_gen: registered maskable interrupt from flags and the selected
 mask set. Assumes flags and masks are synchronous to clock.
*/
`timescale 1ns/100ps
module msmr_irq_gen (
	input wire logic clock,
	input wire logic rst,
	msmr_irq_if.gen  bus
);
	msmr_pkg::msmr_flags_t sel_mask;
	logic                  irq_q;

	assign sel_mask = bus.sel ? bus.mask_b : bus.mask_a;

	always_ff @(posedge clock) begin
		if (rst)
			irq_q <= 1'b0;
		else
			irq_q <= |(bus.flags & sel_mask);
	end
	assign bus.irq = irq_q;

	property p_irq_follows;
		@(posedge clock) disable iff (rst)
		1'b1 |=> irq_q == |($past(bus.flags) & ($past(bus.sel) ? $past(bus.mask_b) : $past(bus.mask_a)));
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("interrupt does not follow masked flags");

	property p_irq_masked_off;
		@(posedge clock) disable iff (rst)
		(bus.mask_a == '0 && bus.mask_b == '0) |=> !irq_q;
	endproperty
	a_irq_masked_off: assert property (p_irq_masked_off) else $error("interrupt set with all masks zero");

	c_irq_rise: cover property (@(posedge clock) disable iff (rst) $rose(irq_q));
endmodule // msmr_irq_gen

// ### testbench/msmr_host_model.sv
/*
 msmr_host_model: byte access host standing in for the two-wire bus master.
 Assumes the access port contract of msmr_top and one shared clock.
*/
`timescale 1ns/100ps
module msmr_host_model (
	input  wire logic       clock,
	input  wire logic [7:0] rd_data_q,
	input  wire logic       rd_valid_q,
	output logic      [7:0] acc_addr,
	output logic            acc_wr,
	output logic            acc_rd,
	output logic      [7:0] acc_wdata
);
	initial begin
		acc_addr = 8'h00;
		acc_wr = 1'b0;
		acc_rd = 1'b0;
		acc_wdata = 8'h00;
	end

	// released data line shows the inverse, not the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		acc_addr <= a;
		acc_wdata <= d;
		acc_wr <= 1'b1;
		@(posedge clock);
		acc_wr <= 1'b0;
		acc_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(posedge clock);
		acc_addr <= a;
		acc_rd <= 1'b1;
		@(posedge clock);
		acc_rd <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (rd_valid_q !== 1'b1 && n < 4);
		// read answer must come exactly one cycle after the strobe is taken
		d = (rd_valid_q === 1'b1 && n == 1) ? rd_data_q : 8'hXX;
	endtask

	task automatic pw(input logic [31:0] p);
		for (int i = 0; i < 4; i++) begin
			wr(8'h7B + 8'(i), p[31-8*i -: 8]);
		end
	endtask
endmodule // msmr_host_model

// ### testbench/testbench.sv
/*
 testbench: self-checking bench for msmr_top; drives conversion and flag
 inputs itself and register accesses through msmr_host_model.
 Assumes a single 100 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
module testbench;
	localparam logic [31:0] PW_LO = 32'h1357_9BDF;
	localparam logic [31:0] PW_HI = 32'h2468_ACE0;
	typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} msmr_row_s;
	logic        clock;
	logic        rst;
	logic [4:0]  conv_done;
	logic        third_above_warn;
	logic        third_below_warn;
	logic        power_range_indicator;
	logic [9:0]  alarm_flags;
	logic [7:0]  other_warn_flags;
	logic [23:0] other_first_masks;
	logic [19:0] second_set_masks;
	logic        mask_set_select;
	logic        shadow_volatile;
	logic [2:0]  table_select_default;
	logic [7:0]  acc_addr;
	logic        acc_wr;
	logic        acc_rd;
	logic [7:0]  acc_wdata;
	logic [7:0]  rd_data_q;
	logic        rd_valid_q;
	logic [2:0]  table_select_q;
	logic [1:0]  third_warn_flags_q;
	logic        lower_password_level_q;
	logic        upper_password_level_q;
	logic        maskable_interrupt_bit;
	logic [7:0]  rdat;
	int          failures;
	int          checks;
	msmr_row_s   rows [11];

	msmr_top #(.LOWER_PASSWORD(PW_LO), .UPPER_PASSWORD(PW_HI)) msmr_top_inst (
		.clock(clock), .rst(rst), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd),
		.acc_wdata(acc_wdata), .conv_done(conv_done), .third_above_warn(third_above_warn),
		.third_below_warn(third_below_warn), .power_range_indicator(power_range_indicator),
		.alarm_flags(alarm_flags), .other_warn_flags(other_warn_flags),
		.other_first_masks(other_first_masks), .second_set_masks(second_set_masks),
		.mask_set_select(mask_set_select), .shadow_volatile(shadow_volatile),
		.table_select_default(table_select_default), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.table_select_q(table_select_q), .third_warn_flags_q(third_warn_flags_q),
		.lower_password_level_q(lower_password_level_q), .upper_password_level_q(upper_password_level_q),
		.maskable_interrupt_bit(maskable_interrupt_bit)
	);

	msmr_host_model msmr_host_model_inst (
		.clock(clock), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .acc_addr(acc_addr),
		.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic finish_test;
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		msmr_host_model_inst.rd(a, rdat);
		chk(rdat, exp, $sformatf("read of %h", a));
	endtask

	task automatic irqchk(input logic e);
		repeat (3) @(posedge clock);
		chk({7'h00, maskable_interrupt_bit}, {7'h00, e}, "interrupt");
	endtask

	task automatic lvlchk(input logic lo, input logic hi);
		repeat (2) @(posedge clock);
		chk({6'h00, upper_password_level_q, lower_password_level_q}, {6'h00, hi, lo}, "levels");
	endtask

	task automatic conv(input logic [4:0] c, input logic hi, input logic lo);
		@(posedge clock);
		conv_done <= c;
		third_above_warn <= hi;
		third_below_warn <= lo;
		@(posedge clock);
		conv_done <= 5'h00;
		@(posedge clock);
	endtask

	task automatic do_reset;
		rst <= 1'b1;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	initial begin
		repeat (5000) @(posedge clock);
		failures++;
		finish_test;
	end

	initial begin
		failures = 0;
		checks = 0;
		rst = 1'b1;
		conv_done = 5'h00;
		third_above_warn = 1'b0;
		third_below_warn = 1'b0;
		power_range_indicator = 1'b0;
		alarm_flags = 10'h000;
		other_warn_flags = 8'h00;
		other_first_masks = 24'h000000;
		second_set_masks = 20'h00000;
		mask_set_select = 1'b0;
		shadow_volatile = 1'b0;
		table_select_default = 3'h5;
		rows = '{'{8'h75, 8'hFF, 8'h00}, '{8'h76, 8'hFF, 8'h00}, '{8'h78, 8'hFF, 8'h00},
			'{8'h7A, 8'hFF, 8'h00}, '{8'h80, 8'h77, 8'h00}, '{8'h7F, 8'hFF, 8'h07},
			'{8'h7F, 8'h01, 8'h01}, '{8'hF7, 8'h5A, 8'h5A}, '{8'hF9, 8'hFF, 8'h00},
			'{8'h7B, 8'hA5, 8'hA5}, '{8'hF8, 8'h00, 8'h00}};
		do_reset;
		chk({5'h00, table_select_q}, 8'h05, "startup table");
		rdchk(8'h77, 8'h00);
		rdchk(8'h7C, 8'h00);
		foreach (rows[i]) begin
			msmr_host_model_inst.wr(rows[i].addr, rows[i].wdata);
			rdchk(rows[i].addr, rows[i].exp);
		end
		rdchk(8'h80, 8'h00);
		msmr_host_model_inst.pw(PW_LO);
		lvlchk(1'b1, 1'b0);
		msmr_host_model_inst.pw(PW_HI);
		lvlchk(1'b1, 1'b1);
		msmr_host_model_inst.pw(PW_LO ^ 32'h0000_0001);
		lvlchk(1'b0, 1'b0);
		conv(5'h01, 1'b1, 1'b0);
		chk({6'h00, third_warn_flags_q}, 8'h02, "warn flags");
		rdchk(8'h75, 8'h80);
		conv(5'h01, 1'b0, 1'b1);
		chk({6'h00, third_warn_flags_q}, 8'h01, "warn flags");
		rdchk(8'h75, 8'h40);
		power_range_indicator <= 1'b1;
		conv(5'h1F, 1'b0, 1'b0);
		rdchk(8'h77, 8'hF9);
		msmr_host_model_inst.wr(8'h77, 8'h00);
		rdchk(8'h77, 8'h01);
		msmr_host_model_inst.wr(8'h77, 8'hFF);
		rdchk(8'h77, 8'h01);
		power_range_indicator <= 1'b0;
		conv(5'h10, 1'b0, 1'b0);
		rdchk(8'h77, 8'h80);
		alarm_flags <= 10'h3FF;
		other_warn_flags <= 8'hFF;
		irqchk(1'b0);
		other_warn_flags <= 8'h00;
		for (int i = 0; i < 8; i++) begin
			alarm_flags <= 10'(1 << (i + 2));
			msmr_host_model_inst.wr(8'hF8, 8'(1 << i));
			irqchk(1'b1);
			msmr_host_model_inst.wr(8'hF8, ~8'(1 << i));
			irqchk(1'b0);
		end
		msmr_host_model_inst.wr(8'hF8, 8'h80);
		irqchk(1'b1);
		mask_set_select <= 1'b1;
		irqchk(1'b0);
		second_set_masks <= 20'h80000;
		irqchk(1'b1);
		mask_set_select <= 1'b0;
		alarm_flags <= 10'h000;
		other_warn_flags <= 8'h01;
		other_first_masks <= 24'h000100;
		irqchk(1'b1);
		other_warn_flags <= 8'h00;
		other_first_masks <= 24'h000080;
		conv(5'h01, 1'b1, 1'b0);
		irqchk(1'b1);
		msmr_host_model_inst.wr(8'hF8, 8'hC3);
		shadow_volatile <= 1'b1;
		msmr_host_model_inst.wr(8'hF8, 8'h3C);
		rdchk(8'hF8, 8'h3C);
		do_reset;
		msmr_host_model_inst.wr(8'h7F, 8'h01);
		rdchk(8'hF8, 8'hC3);
		rdchk(8'hF7, 8'h5A);
		rdchk(8'h7B, 8'h00);
		finish_test;
	end
endmodule // testbench
